//--- design/bmr_pkg.sv
package bmr_pkg;

  // ----------------------------------------------------------------
  // link command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ROM  = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM  = 8'hCC;
  localparam logic [7:0] CMD_CONV_V    = 8'hB4;
  localparam logic [7:0] CMD_CONV_T    = 8'hD2;
  localparam logic [7:0] CMD_READ_MEM  = 8'hA5;
  localparam logic [7:0] CMD_COPY_NV   = 8'h5A;
  localparam logic [7:0] CMD_CYC_INC   = 8'hB5;
  localparam logic [7:0] CMD_CYC_CLR   = 8'hB8;

  // ----------------------------------------------------------------
  // device register byte addresses and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TEMP_LO = 8'h60;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h61;
  localparam logic [7:0] ADDR_STAT_LO = 8'h62;
  localparam logic [7:0] ADDR_STAT_HI = 8'h63;
  localparam logic [7:0] ADDR_VOLT_LO = 8'h77;
  localparam logic [7:0] ADDR_VOLT_HI = 8'h78;
  localparam logic [7:0] ADDR_ID_LO   = 8'h80;
  localparam logic [7:0] ADDR_ID_HI   = 8'h81;
  localparam logic [7:0] ADDR_CYC_LO  = 8'h82;
  localparam logic [7:0] ADDR_CYC_HI  = 8'h83;
  localparam int         STAT_TEMP_BUSY = 0;
  localparam int         STAT_NV_BUSY   = 1;
  localparam int         STAT_LOCK      = 2;
  localparam int         STAT_VOLT_BUSY = 3;
  localparam logic [7:0] STAT_HI_VALUE  = 8'hFF;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hFF;
  localparam logic [4:0] PAGE_LAST      = 5'h1F;
  localparam logic [15:0] CYCLE_MAX     = 16'hFFFF;
  localparam logic [7:0] CRC_POLY_REFL  = 8'h8C;

  // ----------------------------------------------------------------
  // timing at 10 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 10;
  localparam int NV_COPY_US       = 2000;
  localparam int NV_COPY_CYCLES   = NV_COPY_US * CLK_MHZ;
  localparam int VOLT_CONV_US     = 10000;
  localparam int VOLT_CONV_CYCLES = VOLT_CONV_US * CLK_MHZ;
  localparam int TIMER_W          = 17;

  // ----------------------------------------------------------------
  // host register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [1:0] HK_RESET      = 2'h0;
  localparam logic [1:0] HK_WRITE      = 2'h1;
  localparam logic [1:0] HK_READ       = 2'h2;
  localparam logic [1:0] HK_CRC_CLR    = 2'h3;

  typedef enum logic [7:0] {
    DS_WAIT   = 8'h01,
    DS_ROMCMD = 8'h02,
    DS_ROMTX  = 8'h04,
    DS_MATCH  = 8'h08,
    DS_FNCMD  = 8'h10,
    DS_ADDR   = 8'h20,
    DS_READ   = 8'h40,
    DS_CRC    = 8'h80
  } bmr_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_SLOT = 3'h2,
    HS_GAP  = 3'h4
  } bmr_host_state_type;

  function automatic logic [7:0] bmrCrcStep(input logic [7:0] c,
                                            input logic       b);
    logic fb;
    fb = c[0] ^ b;
    bmrCrcStep = (c >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
  endfunction

  function automatic logic [7:0] bmrRomCrc(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = bmrCrcStep(c, d[i]);
    end
    bmrRomCrc = c;
  endfunction

endpackage

//--- design/bmr_link_if.sv
`timescale 1ns/1ps
interface bmr_link_if;
  logic slot;
  logic hostBit;
  logic linkRst;
  logic devBit;
  // wired-and of both drivers, idle high
  wire  dq = hostBit & devBit;

  modport host (output slot, output hostBit, output linkRst, input dq);
  modport dev  (input slot, input linkRst, input dq, output devBit);
endinterface

//--- design/bmr_crc8.sv
`timescale 1ns/1ps
module bmr_crc8 (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       shiftEn,
  input  wire logic       bitIn,
  output logic [7:0]      crc,
  output logic [7:0]      crcNxt
);
  import bmr_pkg::*;

  typedef struct packed {
    logic [7:0] crc;
  } bmr_crc_rec_type;

  bmr_crc_rec_type s_r;
  bmr_crc_rec_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.crc = 8'h00;
    end else if (shiftEn) begin
      s_nxt.crc = bmrCrcStep(s_r.crc, bitIn);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign crc    = s_r.crc;
  assign crcNxt = s_nxt.crc;
endmodule

//--- design/bmr_dev.sv
// What this block does
// - temperature is 13-bit two's complement, 1/32 degree
// - high byte integer, low byte fraction, three zeros
// - two-byte read-only status, upper byte reserved
// - flags at bits 0-3, high nibble zero, FF above
// - temperature busy high while converting
// - copy busy high while copy runs
// - copy busy lasts 2 ms; poll it
// - lock flag shows first user page locked
// - voltage busy high while converting, within 10 ms
// - convert command starts 10-bit voltage conversion
// - voltage straight binary, 10 mV per code
// - factory identifier fixed 16-bit read-only
// - cycle counter kept; increment and clear commands
// - cycle counter low byte at lower address
// - cycle counter saturates, never wraps
// - ROM is family, 48-bit serial, then CRC
// - memory commands ignored until ROM selection done
// - CRC polynomial x8+x5+x4+1 shift register
// - every page read followed by a CRC byte
// - master checks CRC itself and decides
// - device never blocks on CRC mismatch
// - CRC starts zero, ROM CRC closes to zero
// - all link bits travel LSB first
`timescale 1ns/1ps
module bmr_dev #(
  parameter logic [7:0]  FamilyCode   = 8'h5C,
  parameter logic [47:0] SerialNumber = 48'h0000_1234_5678,
  parameter logic [15:0] FactoryId    = 16'hA5C3,
  parameter int          NvCopyCycles = bmr_pkg::NV_COPY_CYCLES,
  parameter int          VoltCycles   = bmr_pkg::VOLT_CONV_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  bmr_link_if.dev          link,
  input  wire logic [12:0] tempCode,
  input  wire logic        tempDone,
  input  wire logic [9:0]  voltCode,
  input  wire logic        voltDone,
  input  wire logic        lockState,
  output logic             tempConvStart,
  output logic             voltConvStart,
  output logic [15:0]      cycleCount
);
  import bmr_pkg::*;

  // family code, serial number and factory id values are arbitrary
  localparam logic [63:0] ROM_ID = {bmrRomCrc({SerialNumber, FamilyCode}),
                                    SerialNumber, FamilyCode};

  typedef struct packed {
    bmr_dev_state_type     st;
    logic [2:0]            bitCnt;
    logic [2:0]            byteCnt;
    logic [7:0]            shift;
    logic [7:0]            addr;
    logic                  devBit;
    logic [15:0]           temp;
    logic [15:0]           volt;
    logic [15:0]           cycle;
    logic                  tempBusy;
    logic                  voltBusy;
    logic                  nvBusy;
    logic [TIMER_W-1:0]    nvTimer;
    logic [TIMER_W-1:0]    voltTimer;
    logic                  tempStart;
    logic                  voltStart;
  } bmr_dev_rec_type;

  bmr_dev_rec_type s_r;
  bmr_dev_rec_type s_nxt;
  logic            crcClr;
  logic            crcShift;
  logic            crcBit;
  logic [7:0]      crcNxt;
  logic [7:0]      rxByte;
  logic            lastBit;

  // ----------------------------------------------------------------
  // register byte read
  // ----------------------------------------------------------------
  function automatic logic [7:0] regByte(input logic [7:0]      a,
                                         input bmr_dev_rec_type s,
                                         input logic            lk);
    logic [7:0] stat;
    stat = 8'h00;
    stat[STAT_TEMP_BUSY] = s.tempBusy;
    stat[STAT_NV_BUSY]   = s.nvBusy;
    stat[STAT_LOCK]      = lk;
    stat[STAT_VOLT_BUSY] = s.voltBusy;
    case (a)
      ADDR_TEMP_LO: regByte = s.temp[7:0];
      ADDR_TEMP_HI: regByte = s.temp[15:8];
      ADDR_STAT_LO: regByte = stat;
      ADDR_STAT_HI: regByte = STAT_HI_VALUE;
      ADDR_VOLT_LO: regByte = s.volt[7:0];
      ADDR_VOLT_HI: regByte = s.volt[15:8];
      ADDR_ID_LO:   regByte = FactoryId[7:0];
      ADDR_ID_HI:   regByte = FactoryId[15:8];
      ADDR_CYC_LO:  regByte = s.cycle[7:0];
      ADDR_CYC_HI:  regByte = s.cycle[15:8];
      default:      regByte = UNMAPPED_VALUE;
    endcase
  endfunction

  bmr_crc8 u_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (crcClr),
    .shiftEn  (crcShift),
    .bitIn    (crcBit),
    .crc      (),
    .crcNxt   (crcNxt)
  );

  assign rxByte  = {link.dq, s_r.shift[7:1]};
  assign lastBit = (s_r.bitCnt == 3'h7);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    s_nxt.tempStart = 1'b0;
    s_nxt.voltStart = 1'b0;
    crcClr          = 1'b0;
    crcShift        = 1'b0;
    crcBit          = s_r.shift[0];

    // measurement and copy completion
    if (s_r.tempBusy && tempDone) begin
      s_nxt.temp     = {tempCode, 3'h0};
      s_nxt.tempBusy = 1'b0;
    end
    if (s_r.voltBusy) begin
      if (voltDone) begin
        s_nxt.volt     = {6'h00, voltCode};
        s_nxt.voltBusy = 1'b0;
      end else if (s_r.voltTimer == TIMER_W'(VoltCycles - 1)) begin
        s_nxt.voltBusy = 1'b0;
      end else begin
        s_nxt.voltTimer = s_r.voltTimer + 1'b1;
      end
    end
    if (s_r.nvBusy) begin
      if (s_r.nvTimer == TIMER_W'(NvCopyCycles - 1)) begin
        s_nxt.nvBusy = 1'b0;
      end else begin
        s_nxt.nvTimer = s_r.nvTimer + 1'b1;
      end
    end

    // link bit slots
    if (link.slot) begin
      s_nxt.bitCnt = s_r.bitCnt + 1'b1;
      case (s_r.st)
        DS_ROMCMD: begin
          s_nxt.shift = rxByte;
          if (lastBit) begin
            case (rxByte)
              CMD_READ_ROM: begin
                s_nxt.st      = DS_ROMTX;
                s_nxt.byteCnt = 3'h0;
                s_nxt.shift   = ROM_ID[7:0];
              end
              CMD_MATCH_ROM: begin
                s_nxt.st      = DS_MATCH;
                s_nxt.byteCnt = 3'h0;
              end
              CMD_SKIP_ROM: s_nxt.st = DS_FNCMD;
              default:      s_nxt.st = DS_WAIT;
            endcase
          end
        end
        DS_ROMTX: begin
          s_nxt.shift = s_r.shift >> 1;
          if (lastBit) begin
            if (s_r.byteCnt == 3'h7) begin
              s_nxt.st = DS_FNCMD;
            end else begin
              s_nxt.byteCnt = s_r.byteCnt + 1'b1;
              s_nxt.shift   =
                ROM_ID[{3'(s_r.byteCnt + 3'h1), 3'h0} +: 8];
            end
          end
        end
        DS_MATCH: begin
          if (link.dq != ROM_ID[{s_r.byteCnt, s_r.bitCnt}]) begin
            s_nxt.st = DS_WAIT;
          end else if (lastBit) begin
            s_nxt.byteCnt = s_r.byteCnt + 1'b1;
            if (s_r.byteCnt == 3'h7) begin
              s_nxt.st = DS_FNCMD;
            end
          end
        end
        DS_FNCMD: begin
          s_nxt.shift = rxByte;
          if (lastBit) begin
            s_nxt.st = DS_WAIT;
            case (rxByte)
              CMD_READ_MEM: s_nxt.st = DS_ADDR;
              CMD_CONV_T: begin
                s_nxt.tempBusy  = 1'b1;
                s_nxt.tempStart = 1'b1;
              end
              CMD_CONV_V: begin
                s_nxt.voltBusy  = 1'b1;
                s_nxt.voltStart = 1'b1;
                s_nxt.voltTimer = '0;
              end
              CMD_COPY_NV: begin
                s_nxt.nvBusy  = 1'b1;
                s_nxt.nvTimer = '0;
              end
              CMD_CYC_INC: begin
                if (s_r.cycle != CYCLE_MAX) begin
                  s_nxt.cycle = s_r.cycle + 1'b1;
                end
              end
              CMD_CYC_CLR: s_nxt.cycle = 16'h0000;
              default:     s_nxt.st = DS_WAIT;
            endcase
          end
        end
        DS_ADDR: begin
          s_nxt.shift = rxByte;
          if (lastBit) begin
            s_nxt.addr  = rxByte;
            s_nxt.shift = regByte(rxByte, s_r, lockState);
            s_nxt.st    = DS_READ;
            crcClr      = 1'b1;
          end
        end
        DS_READ: begin
          crcShift    = 1'b1;
          s_nxt.shift = s_r.shift >> 1;
          if (lastBit) begin
            if (s_r.addr[4:0] == PAGE_LAST) begin
              s_nxt.st    = DS_CRC;
              s_nxt.shift = crcNxt;
            end else begin
              s_nxt.addr  = s_r.addr + 1'b1;
              s_nxt.shift = regByte(8'(s_r.addr + 1'b1), s_r, lockState);
            end
          end
        end
        DS_CRC: begin
          s_nxt.shift = s_r.shift >> 1;
          if (lastBit) begin
            s_nxt.st = DS_WAIT;
          end
        end
        default: s_nxt.st = DS_WAIT;
      endcase
    end

    if (link.linkRst) begin
      s_nxt.st     = DS_ROMCMD;
      s_nxt.bitCnt = 3'h0;
    end

    s_nxt.devBit = (s_nxt.st == DS_ROMTX || s_nxt.st == DS_READ ||
                    s_nxt.st == DS_CRC) ? s_nxt.shift[0] : 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r        <= '0;
      s_r.st     <= DS_WAIT;
      s_r.devBit <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.devBit   = s_r.devBit;
  assign tempConvStart = s_r.tempStart;
  assign voltConvStart = s_r.voltStart;
  assign cycleCount    = s_r.cycle;
endmodule

//--- design/bmr_host.sv
`timescale 1ns/1ps
module bmr_host (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  bmr_link_if.host         link
);
  import bmr_pkg::*;

  typedef struct packed {
    bmr_host_state_type st;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic               wrPend;
    logic               wrCmd;
    logic [9:0]         lastCmd;
    logic [7:0]         shift;
    logic [7:0]         rdByte;
    logic [2:0]         bitCnt;
    logic               isRead;
    logic               slot;
    logic               hostBit;
    logic               linkRst;
  } bmr_host_rec_type;

  bmr_host_rec_type s_r;
  bmr_host_rec_type s_nxt;
  logic             crcClr;
  logic             crcShift;
  logic [7:0]       crcVal;

  bmr_crc8 u_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (crcClr),
    .shiftEn  (crcShift),
    .bitIn    (link.dq),
    .crc      (crcVal),
    .crcNxt   ()
  );

  // ----------------------------------------------------------------
  // bus slave and link sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.linkRst = 1'b0;
    crcClr        = 1'b0;
    crcShift      = 1'b0;

    if (s_r.wrPend) begin
      s_nxt.wrPend = 1'b0;
      if (s_r.wrCmd && s_r.st == HS_IDLE) begin
        s_nxt.lastCmd = hwdata[9:0];
        s_nxt.shift   = hwdata[7:0];
        s_nxt.bitCnt  = 3'h0;
        case (hwdata[9:8])
          HK_RESET:   s_nxt.linkRst = 1'b1;
          HK_CRC_CLR: crcClr = 1'b1;
          HK_WRITE: begin
            s_nxt.isRead  = 1'b0;
            s_nxt.st      = HS_SLOT;
            s_nxt.slot    = 1'b1;
            s_nxt.hostBit = hwdata[0];
          end
          default: begin
            s_nxt.isRead  = 1'b1;
            s_nxt.st      = HS_SLOT;
            s_nxt.slot    = 1'b1;
            s_nxt.hostBit = 1'b1;
          end
        endcase
      end
    end

    if (hsel && htrans[1] && hready) begin
      s_nxt.wrPend = hwrite;
      s_nxt.wrCmd  = (haddr[7:0] == HOST_CMD_OFS);
      if (!hwrite) begin
        case (haddr[7:0])
          HOST_CMD_OFS:  s_nxt.hrdata = {22'h0, s_r.lastCmd};
          HOST_STAT_OFS: s_nxt.hrdata = {8'h00, crcVal, s_r.rdByte,
                                         7'h00, s_r.st != HS_IDLE};
          default:       s_nxt.hrdata = 32'h0000_0000;
        endcase
      end
    end

    case (s_r.st)
      HS_IDLE: s_nxt.slot = s_nxt.slot;
      HS_SLOT: begin
        s_nxt.slot  = 1'b0;
        s_nxt.st    = HS_GAP;
        s_nxt.shift = s_r.shift >> 1;
        if (s_r.isRead) begin
          s_nxt.rdByte = {link.dq, s_r.rdByte[7:1]};
          crcShift     = 1'b1;
        end
      end
      HS_GAP: begin
        s_nxt.bitCnt = s_r.bitCnt + 1'b1;
        if (s_r.bitCnt == 3'h7) begin
          s_nxt.st = HS_IDLE;
        end else begin
          s_nxt.st      = HS_SLOT;
          s_nxt.slot    = 1'b1;
          s_nxt.hostBit = s_r.isRead ? 1'b1 : s_r.shift[0];
        end
      end
      default: s_nxt.st = HS_IDLE;
    endcase
    if (s_nxt.st == HS_IDLE) begin
      s_nxt.hostBit = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r           <= '0;
      s_r.st        <= HS_IDLE;
      s_r.hreadyout <= 1'b1;
      s_r.hostBit   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout    = s_r.hreadyout;
  assign hresp        = s_r.hresp;
  assign hrdata       = s_r.hrdata;
  assign link.slot    = s_r.slot;
  assign link.hostBit = s_r.hostBit;
  assign link.linkRst = s_r.linkRst;
endmodule

//--- verif/bmr_link_chk.sv
`timescale 1ns/1ps
module bmr_link_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slot,
  input wire logic hostBit,
  input wire logic linkRst,
  input wire logic devBit,
  input wire logic dq
);
  // ----------------------------------------------------------------
  // slots since the last link reset, saturating
  // ----------------------------------------------------------------
  logic [3:0] slotCnt_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slotCnt_r <= 4'h0;
    end else if (linkRst) begin
      slotCnt_r <= 4'h0;
    end else if (slot && slotCnt_r != 4'hF) begin
      slotCnt_r <= slotCnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_slot_single: assert property (
    slot |=> !slot) else $error("slot wider than one cycle");
  a_reset_single: assert property (
    linkRst |=> !linkRst) else $error("link reset too wide");
  a_reset_no_slot: assert property (
    linkRst |-> !slot ##1 !slot) else $error("slot beside link reset");
  a_host_idle_high: assert property (
    !slot && !$past(slot) |-> hostBit) else $error("host holds line low");
  a_write_released: assert property (
    slot && !hostBit |-> devBit) else $error("device drives in write");
  a_dev_after_reset: assert property (
    linkRst |-> ##2 devBit[*2]) else $error("device holds after reset");
  a_rom_cmd_quiet: assert property (
    !linkRst && !$past(linkRst) && slotCnt_r < 4'h8 |-> devBit)
    else $error("device drives during command byte");
  a_dev_change_cause: assert property (
    $changed(devBit) |-> $past(slot) || $past(slot, 2) || $past(linkRst)
      || $past(linkRst, 2)) else $error("device bit moved without slot");

  c_dev_zero: cover property (slot && hostBit && !dq);
  c_host_zero: cover property (slot && !hostBit);
  c_link_reset: cover property (linkRst ##[1:40] slot);
endmodule

//--- verif/bmr_tb_top.sv
`timescale 1ns/1ps
module bmr_tb_top;
  import bmr_pkg::*;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam logic [7:0]  FAM    = 8'h3E;              // arbitrary value
  localparam logic [47:0] SER    = 48'h0246_8ACE_1357; // arbitrary value
  localparam logic [15:0] FID    = 16'h6D29;           // arbitrary value
  localparam int          NV_CYC = 300;
  localparam int          V_CYC  = 600;

  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [12:0] tempCode    = 13'h0;
  logic        tempDone    = 1'b0;
  logic [9:0]  voltCode    = 10'h0;
  logic        voltDone    = 1'b0;
  logic        lockState   = 1'b0;
  logic        tempConvStart;
  logic        voltConvStart;
  logic [15:0] cycleCount;
  logic [31:0] stat;
  logic [7:0]  rx [0:32];
  int          errorCnt    = 0;
  int          totalChecks = 0;
  int          tStart      = 0;
  int          vStart      = 0;
  int          cyc         = 0;

  bmr_link_if u_bmr_link_if ();

  bmr_host u_bmr_host (
    .core_clk  (core_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .link      (u_bmr_link_if.host)
  );

  bmr_dev #(
    .FamilyCode   (FAM),
    .SerialNumber (SER),
    .FactoryId    (FID),
    .NvCopyCycles (NV_CYC),
    .VoltCycles   (V_CYC)
  ) u_bmr_dev (
    .core_clk      (core_clk),
    .rst           (rst),
    .link          (u_bmr_link_if.dev),
    .tempCode      (tempCode),
    .tempDone      (tempDone),
    .voltCode      (voltCode),
    .voltDone      (voltDone),
    .lockState     (lockState),
    .tempConvStart (tempConvStart),
    .voltConvStart (voltConvStart),
    .cycleCount    (cycleCount)
  );

  bmr_link_chk u_bmr_link_chk (
    .core_clk (core_clk),
    .rst      (rst),
    .slot     (u_bmr_link_if.slot),
    .hostBit  (u_bmr_link_if.hostBit),
    .linkRst  (u_bmr_link_if.linkRst),
    .devBit   (u_bmr_link_if.devBit),
    .dq       (u_bmr_link_if.dq)
  );

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (tempConvStart === 1'b1) tStart++;
    if (voltConvStart === 1'b1) vStart++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // one link action, then poll until the host is idle again
  task automatic op(input logic [1:0] k, input logic [7:0] b);
    logic [31:0] q;
    ahb(1'b1, HOST_CMD_OFS, {22'h0, k, b}, q);
    do ahb(1'b0, HOST_STAT_OFS, 32'h0, q); while (q[0] !== 1'b0);
    stat = q;
  endtask

  task automatic sel(input logic [7:0] cmd);
    op(HK_RESET, 8'h00);
    op(HK_WRITE, CMD_SKIP_ROM);
    op(HK_WRITE, cmd);
  endtask

  task automatic rdMem(input logic [7:0] a, input int n);
    sel(CMD_READ_MEM);
    op(HK_WRITE, a);
    op(HK_CRC_CLR, 8'h00);
    for (int i = 0; i < n; i++) begin
      op(HK_READ, 8'hFF);
      rx[i] = stat[15:8];
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tstAhb();
    logic [31:0] q;
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF, q);
    ahb(1'b0, 8'h10, 32'h0, q);
    chk(8'(|q), 8'h00);
    chk(8'(hresp), 8'h00);
  endtask

  task automatic tstRom();
    logic [63:0] rom;
    logic [7:0]  c;
    c = 8'h00;
    rom = {8'h00, SER, FAM};
    for (int i = 0; i < 7; i++) c = crc8(c, rom[8*i +: 8]);
    rom[63:56] = c;
    op(HK_RESET, 8'h00);
    op(HK_WRITE, CMD_READ_ROM);
    op(HK_CRC_CLR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      op(HK_READ, 8'hFF);
      chk(stat[15:8], rom[8*i +: 8]);
    end
    chk(stat[23:16], 8'h00);
    // exact match, missed match, then no selection at all
    for (int p = 0; p < 3; p++) begin
      op(HK_RESET, 8'h00);
      if (p < 2) begin
        op(HK_WRITE, CMD_MATCH_ROM);
        for (int i = 0; i < 8; i++) op(HK_WRITE, rom[8*i +: 8] ^ 8'(p));
      end
      op(HK_WRITE, CMD_READ_MEM);
      op(HK_WRITE, ADDR_ID_LO);
      op(HK_READ, 8'hFF);
      chk(stat[15:8], p == 0 ? FID[7:0] : 8'hFF);
    end
  endtask

  task automatic tstTemp();
    logic [15:0] tv [2] = '{16'hE6F0, 16'h1910};
    for (int k = 0; k < 2; k++) begin
      lockState <= (k == 0);
      sel(CMD_CONV_T);
      chk(8'(tStart), 8'(k + 1));
      rdMem(ADDR_STAT_LO, 2);
      chk(rx[0], k == 0 ? 8'h05 : 8'h01);
      tempCode <= tv[k][15:3];
      tempDone <= 1'b1;
      @(posedge core_clk);
      tempDone <= 1'b0;
      rdMem(ADDR_TEMP_LO, 4);
      chk(rx[0], tv[k][7:0]);
      chk(rx[1], tv[k][15:8]);
      chk(rx[2], k == 0 ? 8'h04 : 8'h00);
      chk(rx[3], 8'hFF);
    end
  endtask

  task automatic tstVolt();
    sel(CMD_CONV_V);
    chk(8'(vStart), 8'h01);
    rdMem(ADDR_STAT_LO, 1);
    chk(rx[0], 8'h08);
    voltCode <= 10'h1F4;
    voltDone <= 1'b1;
    @(posedge core_clk);
    voltDone <= 1'b0;
    // second pass: conversion gives up with no result
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        voltCode <= 10'h2D0;
        sel(CMD_CONV_V);
        repeat (V_CYC + 20) @(posedge core_clk);
      end
      rdMem(ADDR_STAT_LO, 23);
      chk(rx[0], 8'h00);
      chk(rx[10], 8'hFF);
      chk(rx[21], 8'hF4);
      chk(rx[22], 8'h01);
    end
    chk(8'(vStart), 8'h02);
  endtask

  task automatic tstNv();
    int t0;
    sel(CMD_COPY_NV);
    t0 = cyc;
    rdMem(ADDR_STAT_LO, 1);
    chk(rx[0], 8'h02);
    while (rx[0] !== 8'h00 && cyc - t0 < 2 * NV_CYC) rdMem(ADDR_STAT_LO, 1);
    chk(rx[0], 8'h00);
    chk(8'(cyc - t0 >= NV_CYC - 8), 8'h01);
  endtask

  task automatic tstCycle();
    logic [7:0] c;
    for (int k = 0; k < 3; k++) sel(CMD_CYC_INC);
    chk(cycleCount[7:0], 8'h03);
    rdMem(ADDR_ID_LO, 33);
    c = 8'h00;
    for (int i = 0; i < 32; i++) c = crc8(c, rx[i]);
    chk(rx[0], FID[7:0]);
    chk(rx[1], FID[15:8]);
    chk(rx[2], 8'h03);
    chk(rx[3], 8'h00);
    chk(rx[31], 8'hFF);
    chk(rx[32], c);
    chk(stat[23:16], 8'h00);
    sel(CMD_CYC_CLR);
    chk(cycleCount[7:0], 8'h00);
    rdMem(ADDR_CYC_LO, 2);
    chk(rx[0] | rx[1], 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    tstAhb();
    tstRom();
    tstTemp();
    tstVolt();
    tstNv();
    tstCycle();
    conclude();
  end

  initial begin
    #(40000 * 100);
    errorCnt++;
    conclude();
  end
endmodule
